// ---- logic/ssrp_defs.svh ----
// Purpose: named constants of the two-wire register port host
// Assumes: 10 MHz reference clock
// Notes: timing counts are derived from the times in their own units
`ifndef SSRP_DEFS_SVH
`define SSRP_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSRP_CLK_NS 100
`define SSRP_SCL_PERIOD_NS 10000
`define SSRP_QTR_CYC (`SSRP_SCL_PERIOD_NS / (4 * `SSRP_CLK_NS))
`define SSRP_QTR_W 5
`define SSRP_TMO_MS 35
`define SSRP_TMO_CYC (`SSRP_TMO_MS * 1000000 / `SSRP_CLK_NS)
`define SSRP_TMO_W 19

// ----------------------------------------------------------------
// bus framing
// ----------------------------------------------------------------
`define SSRP_DEV_ADDR 7'h2e
`define SSRP_RW_WRITE 1'b0
`define SSRP_RW_READ 1'b1
`define SSRP_ACK_BIT 4'h8
`define SSRP_SEG_ADDR 2'h0
`define SSRP_SEG_CMD 2'h1
`define SSRP_SEG_SEC 2'h2
`define SSRP_PH_SDA 2'h0
`define SSRP_PH_RISE 2'h1
`define SSRP_PH_HIGH 2'h2
`define SSRP_PH_FALL 2'h3

`endif

// ---- logic/ssrp_pkg.sv ----
// Purpose: types shared by the register port host modules
// Assumes: nothing
// Notes: constants live in ssrp_defs.svh
package ssrp_pkg;

    // host operations, one per bus protocol
    typedef enum logic [1:0] {
        OP_SEND = 2'b00,
        OP_WRITE = 2'b01,
        OP_RECV = 2'b10,
        OP_READ = 2'b11
    } ssrp_op_e;

    // bus sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_XFER = 2'b10,
        ST_STOP = 2'b11
    } ssrp_state_e;

endpackage

// ---- logic/ssrp_pin_if.sv ----
// Purpose: carries sampled bus levels and the quarter-bit enable
// Assumes: all signals on the reference clock
// Notes: none
interface ssrp_pin_if;
    logic scl_s;
    logic sda_s;
    logic tick;
    modport sync_mp (output scl_s, sda_s);
    modport tick_mp (output tick);
    modport core_mp (input scl_s, sda_s, tick);
endinterface

// ---- logic/ssrp_sync.sv ----
// Purpose: two-flop synchronisers for the bus pins; the quarter-bit divider is in ssrp_tick
// Assumes: pins are asynchronous to the reference clock
// Notes: first stage feeds only the second stage
module ssrp_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // raw pins
    input wire logic scl_raw_in,
    input wire logic sda_raw_in,
    // sampled levels
    ssrp_pin_if.sync_mp pin
);
    import ssrp_pkg::*;

    typedef struct packed {
        logic [1:0] meta;
        logic [1:0] sync;
    } ssrp_sync_s;

    ssrp_sync_s s;
    ssrp_sync_s next_s;

    // idle bus floats high, so reset both stages to one
    always_comb begin
        next_s = s;
        next_s.meta = {scl_raw_in, sda_raw_in};
        next_s.sync = s.meta;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign pin.scl_s = s.sync[1];
    assign pin.sda_s = s.sync[0];
endmodule

// ---- logic/ssrp_tick.sv ----
// Purpose: one-cycle enable at each quarter of the bus clock period
// Assumes: 10 MHz reference clock
// Notes: free running, so the first action after a request waits up to a quarter
`include "ssrp_defs.svh"
module ssrp_tick (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // enable out
    ssrp_pin_if.tick_mp pin
);
    import ssrp_pkg::*;

    typedef struct packed {
        logic [`SSRP_QTR_W-1:0] cnt;
        logic tick;
    } ssrp_tick_s;

    ssrp_tick_s s;
    ssrp_tick_s next_s;

    // divider wraps at the last count and fires the enable there
    always_comb begin
        next_s = s;
        next_s.tick = (s.cnt == `SSRP_QTR_W'(`SSRP_QTR_CYC - 1));
        if (next_s.tick) begin
            next_s.cnt = '0;
        end else begin
            next_s.cnt = s.cnt + `SSRP_QTR_W'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pin.tick = s.tick;
endmodule

// ---- logic/ssrp_host.sv ----
// Purpose: bus master that reads and writes registers of the thermal monitor
// Assumes: open-drain pins with pull-ups; one command at a time
// Notes: each bit takes four quarter-period steps; a step waits while the
//        clock line is held low by the far end
// Functional notes
// - byte is eight bits then acknowledge
// - data changes only while clock low
// - write ends with stop on tenth pulse
// - host no-acknowledges last read byte, then stops
// - read/write bit fixes the direction
// - host always writes pointer as first byte; receive byte writes none and reads at the pointer the device kept
// - repeated start may begin next operation
// - send byte: start, address, command, stop
// - repeated start read straight after pointer write
// - write byte: start, address, command, data, stop
// - receive byte: address read, byte, no-acknowledge, stop
`include "ssrp_defs.svh"
module ssrp_host #(
    parameter int TIMEOUT_CYC = `SSRP_TMO_CYC
) (
    // clock and reset
    input wire logic REF_CLK_IN,
    input wire logic RST_N_IN,
    // command port
    input wire logic CMD_VALID_IN,
    output logic CMD_READY_OUT,
    input wire ssrp_pkg::ssrp_op_e CMD_OP_IN,
    input wire logic [7:0] CMD_PTR_IN,
    input wire logic [7:0] CMD_DATA_IN,
    // result port
    output logic DONE_OUT,
    output logic [7:0] RDATA_OUT,
    output logic NACK_OUT,
    output logic TIMEOUT_OUT,
    // bus pins
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE_OUT,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT
);
    import ssrp_pkg::*;

    // ----------------------------------------------------------------
    // pin sampling and bit timing
    // ----------------------------------------------------------------
    ssrp_pin_if pin ();

    ssrp_sync u_sync (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .scl_raw_in(SCL_IN),
        .sda_raw_in(SDA_IN),
        .pin(pin)
    );

    ssrp_tick u_tick (
        .clk_in(REF_CLK_IN),
        .rst_n_in(RST_N_IN),
        .pin(pin)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        ssrp_state_e fsm;
        ssrp_op_e op;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [1:0] seg;
        logic rd;
        logic ack;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic [7:0] data;
        logic scl_oe;
        logic sda_oe;
        logic [`SSRP_TMO_W-1:0] tmo;
        logic err_nack;
        logic err_tmo;
        logic [7:0] rdata;
        logic done;
    } ssrp_host_s;

    ssrp_host_s s;
    ssrp_host_s next_s;
    logic step;
    logic waiting;
    logic addr_rw;

    // a step waits in the high phase until the clock line is seen high,
    // so a far end that stretches the clock slows the whole transfer
    assign waiting = (s.fsm != ST_IDLE) && (s.ph == `SSRP_PH_HIGH) && !pin.scl_s;
    assign step = pin.tick && !waiting;
    // address byte direction: read for receive byte and for the second
    // address of a combined read
    assign addr_rw = (s.op == OP_RECV) || ((s.op == OP_READ) && (s.seg == `SSRP_SEG_SEC))
        ? `SSRP_RW_READ : `SSRP_RW_WRITE;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.tmo = waiting ? s.tmo + `SSRP_TMO_W'(1) : '0;
        unique case (s.fsm)
            ST_IDLE: begin
                next_s.scl_oe = 1'b0;
                next_s.sda_oe = 1'b0;
                if (CMD_VALID_IN) begin
                    next_s.op = CMD_OP_IN;
                    next_s.ptr = CMD_PTR_IN;
                    next_s.data = CMD_DATA_IN;
                    next_s.seg = `SSRP_SEG_ADDR;
                    next_s.ph = `SSRP_PH_SDA;
                    next_s.rd = 1'b0;
                    next_s.err_nack = 1'b0;
                    next_s.err_tmo = 1'b0;
                    next_s.fsm = ST_START;
                end
            end
            // start and repeated start share one sequence: release data,
            // release clock, pull data low with clock high, pull clock low
            ST_START: begin
                if (step) begin
                    next_s.ph = s.ph + 2'h1;
                    unique case (s.ph)
                        `SSRP_PH_SDA: next_s.sda_oe = 1'b0;
                        `SSRP_PH_RISE: next_s.scl_oe = 1'b0;
                        `SSRP_PH_HIGH: next_s.sda_oe = 1'b1;
                        `SSRP_PH_FALL: begin
                            next_s.scl_oe = 1'b1;
                            next_s.sh = {`SSRP_DEV_ADDR, addr_rw};
                            next_s.bitn = '0;
                            next_s.rd = 1'b0;
                            next_s.fsm = ST_XFER;
                        end
                    endcase
                end
            end
            ST_XFER: begin
                if (step) begin
                    next_s.ph = s.ph + 2'h1;
                    unique case (s.ph)
                        `SSRP_PH_SDA: begin
                            // data set up only while the clock is held low;
                            // on the acknowledge slot the line is released, which
                            // also gives the no-acknowledge after a read byte
                            next_s.sda_oe = (s.bitn != `SSRP_ACK_BIT) && !s.rd
                                && !s.sh[7];
                        end
                        `SSRP_PH_RISE: next_s.scl_oe = 1'b0;
                        `SSRP_PH_HIGH: begin
                            if (s.bitn != `SSRP_ACK_BIT) begin
                                next_s.sh = {s.sh[6:0], pin.sda_s};
                            end else begin
                                next_s.ack = pin.sda_s;
                            end
                        end
                        `SSRP_PH_FALL: begin
                            next_s.scl_oe = 1'b1;
                            if (s.bitn != `SSRP_ACK_BIT) begin
                                next_s.bitn = s.bitn + 4'h1;
                            end else if (s.rd) begin
                                // one byte per read, then stop
                                next_s.rdata = s.sh;
                                next_s.fsm = ST_STOP;
                            end else if (s.ack) begin
                                // no acknowledge from the far end: abandon
                                next_s.err_nack = 1'b1;
                                next_s.fsm = ST_STOP;
                            end else if (addr_rw == `SSRP_RW_READ
                                && s.seg != `SSRP_SEG_CMD) begin
                                next_s.rd = 1'b1;
                                next_s.bitn = '0;
                                next_s.seg = s.seg + 2'h1;
                            end else if (s.op == OP_READ && s.seg == `SSRP_SEG_CMD) begin
                                // repeated start right after the pointer ack
                                next_s.seg = `SSRP_SEG_SEC;
                                next_s.fsm = ST_START;
                            end else if ((s.op == OP_SEND && s.seg == `SSRP_SEG_CMD)
                                || (s.op == OP_WRITE && s.seg == `SSRP_SEG_SEC)) begin
                                next_s.fsm = ST_STOP;
                            end else begin
                                // pointer always goes first, data second
                                next_s.sh = (s.seg == `SSRP_SEG_ADDR)
                                    ? s.ptr : s.data;
                                next_s.bitn = '0;
                                next_s.seg = s.seg + 2'h1;
                            end
                        end
                    endcase
                end
            end
            // stop: pull data low with clock low, release clock, then
            // release data while the clock is high
            ST_STOP: begin
                if (step) begin
                    next_s.ph = s.ph + 2'h1;
                    unique case (s.ph)
                        `SSRP_PH_SDA: next_s.sda_oe = 1'b1;
                        `SSRP_PH_RISE: next_s.scl_oe = 1'b0;
                        `SSRP_PH_HIGH: next_s.sda_oe = 1'b0;
                        `SSRP_PH_FALL: begin
                            next_s.done = 1'b1;
                            next_s.fsm = ST_IDLE;
                        end
                    endcase
                end
            end
        endcase
        // a clock held low for too long: let go of both lines and report,
        // rather than hang with the bus half driven
        if (waiting && s.tmo == TIMEOUT_CYC[`SSRP_TMO_W-1:0]) begin
            next_s.scl_oe = 1'b0;
            next_s.sda_oe = 1'b0;
            next_s.err_tmo = 1'b1;
            next_s.done = 1'b1;
            next_s.tmo = '0;
            next_s.fsm = ST_IDLE;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RST_N_IN) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // open drain: the pins only ever pull low
    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE_OUT = s.scl_oe;
    assign SDA_OE_OUT = s.sda_oe;
    assign CMD_READY_OUT = (s.fsm == ST_IDLE) && RST_N_IN;
    assign DONE_OUT = s.done;
    assign RDATA_OUT = s.rdata;
    assign NACK_OUT = s.err_nack;
    assign TIMEOUT_OUT = s.err_tmo;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_sda_moves_clock_low;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (s.fsm == ST_XFER && $changed(s.sda_oe)) |-> (s.scl_oe && $past(s.scl_oe));
    endproperty
    a_sda_moves_clock_low: assert property (p_sda_moves_clock_low)
        else $error("data line moved while clock released");

    property p_write_ack_released;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (s.fsm == ST_XFER && !s.rd && s.bitn == `SSRP_ACK_BIT && s.ph == `SSRP_PH_HIGH)
            |-> !s.sda_oe && !s.scl_oe;
    endproperty
    a_write_ack_released: assert property (p_write_ack_released)
        else $error("host drives data in acknowledge slot");

    property p_read_nack;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (s.fsm == ST_XFER && s.rd && s.bitn == `SSRP_ACK_BIT && !s.scl_oe)
            |-> !s.sda_oe;
    endproperty
    a_read_nack: assert property (p_read_nack)
        else $error("host acknowledged a read byte");

    property p_read_bits_released;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (s.fsm == ST_XFER && s.rd && s.ph == `SSRP_PH_RISE) |-> !s.sda_oe [*3];
    endproperty
    a_read_bits_released: assert property (p_read_bits_released)
        else $error("host drives data during a read byte");

    property p_stop_edge;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (s.fsm == ST_STOP && $fell(s.sda_oe)) |-> !s.scl_oe ##1 s.fsm == ST_STOP;
    endproperty
    a_stop_edge: assert property (p_stop_edge)
        else $error("stop edge without clock high");

    property p_address_first;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (s.fsm == ST_XFER && $past(s.fsm) == ST_START)
            |-> s.sh[7:1] == `SSRP_DEV_ADDR && s.bitn == 4'h0;
    endproperty
    a_address_first: assert property (p_address_first)
        else $error("first byte is not the device address");

    property p_combined_read;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        (s.fsm == ST_XFER && $past(s.fsm) == ST_START && s.op == OP_READ
            && s.seg == `SSRP_SEG_SEC) |-> s.sh[0] == `SSRP_RW_READ;
    endproperty
    a_combined_read: assert property (p_combined_read)
        else $error("repeated start not followed by read address");

    property p_pointer_first;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        ($changed(s.seg) && s.seg == `SSRP_SEG_CMD && s.op != OP_RECV)
            |-> s.sh == s.ptr && !s.rd;
    endproperty
    a_pointer_first: assert property (p_pointer_first)
        else $error("first written byte is not the pointer");

    property p_write_length;
        @(posedge REF_CLK_IN) disable iff (!RST_N_IN)
        ($past(s.fsm) == ST_XFER && s.fsm == ST_STOP && !s.err_nack && !$past(s.rd))
            |-> (s.op == OP_SEND && s.seg == `SSRP_SEG_CMD)
            || (s.op == OP_WRITE && s.seg == `SSRP_SEG_SEC);
    endproperty
    a_write_length: assert property (p_write_length)
        else $error("write ended after the wrong byte count");
endmodule

// ---- testbench/ssrp_dev_model.sv ----
// Purpose: behavioural model of the monitored device's two-wire slave port
// Assumes: open-drain lines with pull-ups, so a released line reads high
// Notes: idle timeout is far longer than any run; registers are reached by hierarchy
`include "ssrp_defs.svh"
module ssrp_dev_model (
    // bus lines
    input wire logic scl_in,
    input wire logic sda_in,
    // faults commanded by the bench
    input wire logic nack_in,
    input wire logic hold_in,
    input wire logic [31:0] stretch_ns_in,
    // pull-downs
    output logic sda_oe_out,
    output wire logic scl_oe_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [256];
    logic [7:0] ptr = 8'h00;
    logic [7:0] sh = 8'h00;
    logic rd = 1'b0;
    logic act = 1'b0;
    logic stretch = 1'b0;
    int cnt = 0;
    int nbyte = 0;
    logic bus_timeout_disable = 1'b0;
    time last_edge = 0;
    initial sda_oe_out = 1'b0;
    // no line activity for the idle limit: give up the data line
    always @(scl_in or sda_in) last_edge = $time;
    always #1000 begin
        if (act && !bus_timeout_disable && ($time - last_edge) >= (`SSRP_TMO_MS * 1000000)) begin
            act = 1'b0;
            sda_oe_out = 1'b0;
        end
    end
    // a stuck or stretched clock exercises the host's wait logic
    assign scl_oe_out = hold_in | stretch;
    always @(negedge scl_in) begin
        if (stretch_ns_in > 0) begin
            stretch = 1'b1;
            #(stretch_ns_in);
            stretch = 1'b0;
        end
    end
    // start or repeated start opens a new operation
    always @(negedge sda_in) begin
        if (scl_in) begin
            act = 1'b1;
            rd = 1'b0;
            cnt = -1;
            nbyte = 0;
            sda_oe_out = 1'b0;
        end
    end
    // stop ends the operation, pointer kept
    always @(posedge sda_in) begin
        if (scl_in) begin
            act = 1'b0;
            sda_oe_out = 1'b0;
        end
    end
    // sample in the high phase, msb first
    always @(posedge scl_in) begin
        if (act && cnt >= 0 && cnt < 8 && !(rd && nbyte > 0)) sh = {sh[6:0], sda_in};
        if (act && cnt == 8 && rd && nbyte > 0 && sda_in) act = 1'b0;
    end
    // drive only in the low phase
    always @(negedge scl_in) begin
        if (act) begin
            cnt = cnt + 1;
            if (cnt == 9) begin
                cnt = 0;
                nbyte = nbyte + 1;
                sh = regs[ptr];
                sda_oe_out = rd && !sh[7];
            end else if (cnt == 8 && nbyte == 0) begin
                // own address only; r/w bit fixes direction
                rd = sh[0];
                act = sh[7:1] == `SSRP_DEV_ADDR && !nack_in;
                sda_oe_out = act;
            end else if (cnt == 8 && !rd) begin
                // pointer first, then register
                if (nbyte == 1) ptr = sh;
                if (nbyte == 2) regs[ptr] = sh;
                sda_oe_out = nbyte < 3;
            end else begin
                sda_oe_out = rd && nbyte > 0 && cnt < 8 && !sh[7 - cnt];
            end
        end
    end
    initial for (int i = 0; i < 256; i++) regs[i] = 8'h00;
endmodule

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the register port host
// Assumes: pull-ups on both lines, device model on the far side
// Notes: a short timeout parameter keeps the stuck-clock case quick
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import ssrp_pkg::*;
    localparam int TMO = 200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic valid = 1'b0;
    ssrp_op_e op = OP_SEND;
    logic [7:0] ptr = 8'h00;
    logic [7:0] data = 8'h00;
    logic ready, done, nack, tmo, scl_oe, sda_oe, dev_sda_oe, dev_scl_oe, scl_o, sda_o;
    logic [7:0] rdata;
    logic nack_f = 1'b0;
    logic hold = 1'b0;
    int stretch_ns = 0;
    int miscompares = 0;
    int samples_checked = 0;
    // wired-and of both parties, pull-ups make released lines high
    // the host's pin value is used while it drives, so a wrong level shows on the wire
    wire scl_w = (scl_oe ? scl_o : 1'b1) & !dev_scl_oe;
    wire sda_w = (sda_oe ? sda_o : 1'b1) & !dev_sda_oe;
    ssrp_host #(.TIMEOUT_CYC(TMO)) dut (
        .REF_CLK_IN(clk), .RST_N_IN(rst_n), .CMD_VALID_IN(valid), .CMD_READY_OUT(ready),
        .CMD_OP_IN(op), .CMD_PTR_IN(ptr), .CMD_DATA_IN(data), .DONE_OUT(done),
        .RDATA_OUT(rdata), .NACK_OUT(nack), .TIMEOUT_OUT(tmo), .SCL_IN(scl_w),
        .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_o),
        .SDA_OE_OUT(sda_oe));
    ssrp_dev_model dev (
        .scl_in(scl_w), .sda_in(sda_w), .nack_in(nack_f), .hold_in(hold),
        .stretch_ns_in(stretch_ns), .sda_oe_out(dev_sda_oe), .scl_oe_out(dev_scl_oe));
    // last address byte seen on the wire after a start
    logic [7:0] mon_sh = 8'h00;
    logic [7:0] mon_addr = 8'h00;
    int mon_cnt = 99;
    always @(negedge sda_w) if (scl_w) mon_cnt = 0;
    always @(posedge scl_w) begin
        if (mon_cnt < 8) mon_sh = {mon_sh[6:0], sda_w};
        if (mon_cnt == 7) mon_addr = mon_sh;
        mon_cnt = mon_cnt + 1;
    end
    initial forever #50 clk = ~clk;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // ready and done waits are bounded; running out ends the run
    task automatic run_cmd(input ssrp_op_e o, input logic [7:0] p, input logic [7:0] d);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            step();
            n++;
        end
        if (ready !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
        op = o;
        ptr = p;
        data = d;
        valid = 1'b1;
        step();
        valid = 1'b0;
        check({7'h0, ready}, 8'h00);
        while (done !== 1'b1 && n < 20000) begin
            step();
            n++;
        end
        if (n >= 20000) begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic t_reset();
        repeat (4) step();
        check({2'h0, ready, done, nack, tmo, scl_oe, sda_oe}, 8'h00);
        check(rdata, 8'h00);
        check({6'h0, scl_o, sda_o}, 8'h00);
        rst_n = 1'b1;
        step();
        check({7'h0, ready}, 8'h01);
    endtask
    task automatic t_write_read();
        dev.regs[8'h33] = 8'hc3;
        run_cmd(OP_WRITE, 8'h10, 8'ha5);
        check(dev.regs[8'h10], 8'ha5);
        check(mon_addr, 8'h5c);
        check({6'h0, scl_w, sda_w}, 8'h03);
        run_cmd(OP_READ, 8'h33, 8'h00);
        check(rdata, 8'hc3);
        check(mon_addr, 8'h5d);
        check({6'h0, scl_w, sda_w}, 8'h03);
    endtask
    task automatic t_send_recv();
        dev.regs[8'h21] = 8'h5e;
        run_cmd(OP_SEND, 8'h21, 8'hff);
        check(dev.ptr, 8'h21);
        check(dev.regs[8'h21], 8'h5e);
        repeat (2) begin
            run_cmd(OP_RECV, 8'h00, 8'h00);
            check(rdata, 8'h5e);
        end
    endtask
    // stretch past the high-phase step so the host really has to wait
    task automatic t_stretch();
        time t0;
        stretch_ns = 9000;
        t0 = $time;
        run_cmd(OP_WRITE, 8'h44, 8'h81);
        check({7'h0, ($time - t0) > 320000}, 8'h01);
        run_cmd(OP_RECV, 8'h00, 8'h00);
        check(rdata, 8'h81);
        stretch_ns = 0;
    endtask
    task automatic t_nack();
        nack_f = 1'b1;
        run_cmd(OP_WRITE, 8'h10, 8'h00);
        check({7'h0, nack}, 8'h01);
        check(dev.regs[8'h10], 8'ha5);
        nack_f = 1'b0;
        run_cmd(OP_RECV, 8'h00, 8'h00);
        check({7'h0, nack}, 8'h00);
        check(rdata, 8'h81);
    endtask
    task automatic t_timeout();
        hold = 1'b1;
        run_cmd(OP_SEND, 8'h00, 8'h00);
        check({6'h0, tmo, nack}, 8'h02);
        check({6'h0, scl_oe, sda_oe}, 8'h00);
        hold = 1'b0;
        run_cmd(OP_WRITE, 8'h7c, 8'h3a);
        check({6'h0, tmo, nack}, 8'h00);
        check(dev.regs[8'h7c], 8'h3a);
    endtask
    initial begin
        t_reset();
        t_write_read();
        t_send_recv();
        t_stretch();
        t_nack();
        t_timeout();
        tally_and_finish();
    end
endmodule
